// file: verilog/lsm_pkg.sv
// Purpose: shared constants and types for the logic slice group
// Assumes: one clock, synchronous active-high reset
// Notes: the counter clear is the one asynchronous input
package lsm_pkg;
   localparam int TABLE_DEPTH = 16;
   localparam int SEL_W = 4;
   localparam int DATA_W = 2;
   localparam int RAM_W = 4;
   localparam int CFG_TABLES_W = RAM_W * TABLE_DEPTH;
   localparam logic [TABLE_DEPTH-1:0] TABLE_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] COUNT_RESET = 2'h0;
   localparam logic [DATA_W-1:0] COUNT_STEP = 2'h1;
   localparam logic [DATA_W-1:0] ALL_PROP = 2'h3;

   typedef enum logic [1:0] {
      MODE_LOGIC  = 2'b00,
      MODE_RIPPLE = 2'b01,
      MODE_RAM    = 2'b10,
      MODE_ROM    = 2'b11
   } lsm_mode_t;

   typedef enum logic [2:0] {
      OP_ADD    = 3'b000,
      OP_SUB    = 3'b001,
      OP_ADDSUB = 3'b010,
      OP_CNT_UP = 3'b011,
      OP_CNT_DN = 3'b100,
      OP_CNT_UD = 3'b101,
      OP_CMP    = 3'b110,
      OP_MULT   = 3'b111
   } lsm_op_t;
endpackage : lsm_pkg

// file: verilog/lsm_four_input_table.sv
// Purpose: one four-input table, usable as logic or as a 16x1 column
// Assumes: load and write come from the same clock domain
// Notes: load wins over a write in the same cycle
`timescale 1ns/10ps
`default_nettype none
module lsm_four_input_table
   import lsm_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // configuration
   input wire logic i_cfg_load,
   input wire logic [TABLE_DEPTH-1:0] i_cfg_init,
   // write port
   input wire logic i_wr_en,
   input wire logic [SEL_W-1:0] i_wr_addr,
   input wire logic i_wr_bit,
   // read port
   input wire logic [SEL_W-1:0] i_rd_addr,
   output logic o_rd_bit
);
   logic [TABLE_DEPTH-1:0] table_reg;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         table_reg <= TABLE_RESET;
      end else if (i_cfg_load) begin
         table_reg <= i_cfg_init;
      end else if (i_wr_en) begin
         table_reg[i_wr_addr] <= i_wr_bit;
      end
   end

   // one entry per input combination
   assign o_rd_bit = table_reg[i_rd_addr];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   a_table_preload: assert property (
      i_cfg_load |=> (table_reg == $past(i_cfg_init)))
      else $error("table not preloaded from configuration");
endmodule : lsm_four_input_table
`default_nettype wire

// file: verilog/lsm_slice.sv
// Purpose: three-slice group with logic, ripple, ram and rom modes
// Assumes: fabric inputs share i_mclk; i_count_clr may be asynchronous
// Notes: tables 0-1 belong to slice 0, tables 2-3 to slice 1
`timescale 1ns/10ps
`default_nettype none
module lsm_slice
   import lsm_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // configuration
   input wire logic i_cfg_load,
   input wire logic [1:0] i_cfg_mode,
   input wire logic [2:0] i_cfg_op,
   input wire logic i_cfg_fast,
   input wire logic [CFG_TABLES_W-1:0] i_cfg_tables,
   // logic mode
   input wire logic [SEL_W-1:0] i_lut_in,
   input wire logic i_lut_sel5,
   input wire logic i_fx_lo,
   input wire logic i_fx_hi,
   input wire logic i_fx_sel,
   output logic o_f0,
   output logic o_f1,
   output logic o_f5,
   output logic o_fx,
   // ripple mode operands and chain
   input wire logic [DATA_W-1:0] i_op_a,
   input wire logic [DATA_W-1:0] i_op_b,
   input wire logic i_carry_in,
   input wire logic i_add_nsub,
   input wire logic i_mult_bit,
   output logic [DATA_W-1:0] o_sum,
   output logic o_carry_out,
   output logic o_cgen,
   output logic o_cprop,
   output logic o_ge,
   output logic o_ne,
   output logic o_le,
   // counter
   input wire logic i_count_clr,
   input wire logic i_count_up,
   input wire logic i_preload,
   input wire logic [DATA_W-1:0] i_preload_val,
   output logic [DATA_W-1:0] o_count,
   // distributed memory
   input wire logic [SEL_W-1:0] i_ram_addr,
   input wire logic i_ram_we,
   input wire logic [RAM_W-1:0] i_ram_wdata,
   output logic [RAM_W-1:0] o_ram_rdata
);
   lsm_mode_t mode_reg;
   lsm_op_t op_reg;
   logic fast_reg;
   logic [RAM_W-1:0] table_out;
   logic [SEL_W-1:0] rd_addr;
   logic [SEL_W-1:0] ctl_addr;
   logic ctl_we;
   logic is_ripple;
   logic is_arith;
   logic is_count;
   logic sub_sel;
   logic [DATA_W-1:0] addend_a;
   logic [DATA_W-1:0] addend_b;
   logic [DATA_W:0] sum_full;
   logic [DATA_W:0] sum_nocin;
   logic [DATA_W-1:0] sum_reg;
   logic [DATA_W-1:0] count_reg;
   logic [DATA_W-1:0] count_next;
   logic ge_reg;
   logic ne_reg;
   logic le_reg;

   // ----------------------------------------------------------------
   // mode configuration
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         mode_reg <= MODE_LOGIC;
         op_reg <= OP_ADD;
         fast_reg <= 1'b0;
      end else if (i_cfg_load) begin
         mode_reg <= lsm_mode_t'(i_cfg_mode);
         op_reg <= lsm_op_t'(i_cfg_op);
         fast_reg <= i_cfg_fast;
      end
   end

   // ----------------------------------------------------------------
   // control slice: address and write enable for the storage slices
   // ----------------------------------------------------------------
   assign ctl_addr = i_ram_addr;
   // rom and other modes never write
   assign ctl_we = i_ram_we && (mode_reg == MODE_RAM);
   assign rd_addr = (mode_reg == MODE_LOGIC) ? i_lut_in : ctl_addr;

   // ----------------------------------------------------------------
   // storage slices: four 16x1 columns
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < RAM_W; gi++) begin : g_col
         lsm_four_input_table u_table (
            .i_mclk(i_mclk),
            .i_reset(i_reset),
            .i_cfg_load(i_cfg_load),
            .i_cfg_init(i_cfg_tables[gi*TABLE_DEPTH +: TABLE_DEPTH]),
            .i_wr_en(ctl_we),
            .i_wr_addr(ctl_addr),
            .i_wr_bit(i_ram_wdata[gi]),
            .i_rd_addr(rd_addr),
            .o_rd_bit(table_out[gi])
         );
      end
   endgenerate

   // combinational read of the addressed word
   assign o_ram_rdata = table_out;

   // ----------------------------------------------------------------
   // logic mode outputs
   // ----------------------------------------------------------------
   assign o_f0 = table_out[0];
   assign o_f1 = table_out[1];
   // two tables of this slice form a five-input function
   assign o_f5 = i_lut_sel5 ? table_out[1] : table_out[0];
   // neighbouring slice outputs combine into wider functions
   assign o_fx = i_fx_sel ? i_fx_hi : i_fx_lo;

   // ----------------------------------------------------------------
   // ripple arithmetic datapath
   // ----------------------------------------------------------------
   assign is_ripple = (mode_reg == MODE_RIPPLE);
   assign is_arith = is_ripple && (op_reg == OP_ADD || op_reg == OP_SUB ||
                                   op_reg == OP_ADDSUB || op_reg == OP_MULT);
   assign is_count = is_ripple && (op_reg == OP_CNT_UP || op_reg == OP_CNT_DN ||
                                   op_reg == OP_CNT_UD);
   // dynamic control picks add or subtract
   assign sub_sel = (op_reg == OP_SUB) ||
                    (op_reg == OP_ADDSUB && !i_add_nsub);
   // partial product gated by the multiplier bit
   assign addend_a = (op_reg == OP_MULT) ?
                     (i_op_a & {DATA_W{i_mult_bit}}) : i_op_a;
   assign addend_b = sub_sel ? ~i_op_b : i_op_b;
   assign sum_full = {1'b0, addend_a} + {1'b0, addend_b} + {{DATA_W{1'b0}}, i_carry_in};
   assign sum_nocin = {1'b0, addend_a} + {1'b0, addend_b};

   // carry chain into the next slice
   assign o_carry_out = is_arith ? sum_full[DATA_W] : 1'b0;
   assign o_cgen = (is_arith && fast_reg) ? sum_nocin[DATA_W] : 1'b0;
   assign o_cprop = (is_arith && fast_reg) ?
                    ((addend_a ^ addend_b) == ALL_PROP) : 1'b0;

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         sum_reg <= COUNT_RESET;
      end else if (is_arith) begin
         sum_reg <= sum_full[DATA_W-1:0];
      end
   end
   assign o_sum = sum_reg;

   // ----------------------------------------------------------------
   // comparator
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         ge_reg <= 1'b0;
         ne_reg <= 1'b0;
         le_reg <= 1'b0;
      end else if (is_ripple && op_reg == OP_CMP) begin
         ge_reg <= (i_op_a >= i_op_b);
         ne_reg <= (i_op_a != i_op_b);
         le_reg <= (i_op_a <= i_op_b);
      end
   end
   assign o_ge = ge_reg;
   assign o_ne = ne_reg;
   assign o_le = le_reg;

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   always_comb begin
      case (op_reg)
         OP_CNT_UP: count_next = count_reg + COUNT_STEP;
         OP_CNT_DN: count_next = count_reg - COUNT_STEP;
         OP_CNT_UD: count_next = i_count_up ? count_reg + COUNT_STEP :
                                              count_reg - COUNT_STEP;
         default: count_next = count_reg;
      endcase
   end

   // clear acts without the clock, preload waits for the edge
   always_ff @(posedge i_mclk or posedge i_count_clr) begin
      if (i_count_clr) begin
         count_reg <= COUNT_RESET;
      end else if (i_reset) begin
         count_reg <= COUNT_RESET;
      end else if (is_count && i_preload) begin
         count_reg <= i_preload_val;
      end else if (is_count) begin
         count_reg <= count_next;
      end
   end
   assign o_count = count_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset || i_count_clr);

   sequence s_ram_write;
      mode_reg == MODE_RAM && i_ram_we && !i_cfg_load ##1
         i_ram_addr == $past(i_ram_addr) && !$past(i_cfg_load);
   endsequence

   sequence s_rom_write;
      mode_reg == MODE_ROM && i_ram_we && !i_cfg_load ##1
         i_ram_addr == $past(i_ram_addr) && !$past(i_cfg_load);
   endsequence

   sequence s_count_up_step;
      is_count && op_reg == OP_CNT_UP && !i_preload && !i_cfg_load;
   endsequence

   a_mode_taken: assert property (
      i_cfg_load |=> (mode_reg == $past(i_cfg_mode)) && (op_reg == $past(i_cfg_op)))
      else $error("mode not taken from configuration");

   a_five_input: assert property (
      mode_reg == MODE_LOGIC |-> o_f5 == (i_lut_sel5 ? o_f1 : o_f0))
      else $error("five-input function selects wrong table");

   a_add_sum: assert property (
      (is_arith && op_reg == OP_ADD && !i_cfg_load) |=>
         o_sum == $past(i_op_a + i_op_b + {1'b0, i_carry_in}))
      else $error("ripple sum wrong");

   a_sub_diff: assert property (
      (is_arith && op_reg == OP_ADDSUB && !i_add_nsub && i_carry_in && !i_cfg_load) |=>
         o_sum == $past(i_op_a - i_op_b))
      else $error("ripple difference wrong");

   a_count_up: assert property (
      s_count_up_step |=> o_count == $past(o_count) + COUNT_STEP)
      else $error("up counter did not step");

   a_count_preload: assert property (
      (is_count && i_preload && !i_cfg_load) |=> o_count == $past(i_preload_val))
      else $error("counter preload not applied");

   a_count_down: assert property (
      (is_count && op_reg == OP_CNT_DN && !i_preload && !i_cfg_load) |=>
         o_count == $past(o_count) - COUNT_STEP)
      else $error("down counter did not step");

   a_count_updown: assert property (
      (is_count && op_reg == OP_CNT_UD && !i_preload && !i_cfg_load) |=>
         o_count == ($past(i_count_up) ? $past(o_count) + COUNT_STEP :
                                         $past(o_count) - COUNT_STEP))
      else $error("up/down counter stepped the wrong way");

   // clear must win without waiting for the clock
   a_count_clear: assert property (
      disable iff (i_reset) i_count_clr |-> o_count == COUNT_RESET)
      else $error("counter not held clear");

   a_mult_step: assert property (
      (is_arith && op_reg == OP_MULT && !i_cfg_load) |=>
         o_sum == $past((i_op_a & {DATA_W{i_mult_bit}}) + i_op_b + {1'b0, i_carry_in}))
      else $error("partial product sum wrong");

   a_sum_hold: assert property (
      !is_arith |=> $stable(o_sum))
      else $error("sum changed outside arithmetic ops");

   a_carry_off: assert property (
      !(is_arith && fast_reg) |-> !o_cgen && !o_cprop)
      else $error("generate or propagate active without fast carry");

   a_compare_flags: assert property (
      (is_ripple && op_reg == OP_CMP && !i_cfg_load) |=>
         o_ge == ($past(i_op_a) >= $past(i_op_b)) &&
         o_le == ($past(i_op_a) <= $past(i_op_b)) &&
         o_ne == ($past(i_op_a) != $past(i_op_b)))
      else $error("comparator flags wrong");

   a_fast_carry: assert property (
      (is_arith && fast_reg) |-> o_carry_out == (o_cgen || (o_cprop && i_carry_in)))
      else $error("carry generate and propagate disagree with carry");

   a_ram_write: assert property (
      s_ram_write |-> o_ram_rdata == $past(i_ram_wdata))
      else $error("ram write not read back");

   a_rom_fixed: assert property (
      s_rom_write |-> o_ram_rdata == $past(o_ram_rdata))
      else $error("rom contents changed by a write");
endmodule : lsm_slice
`default_nettype wire

// file: sim/lsm_fabric_model.sv
// Purpose: neighbour slices feeding the wide-function mux of the slice
// Assumes: neighbours are plain combinational tables on the same select
// Notes: low neighbour gives parity, high neighbour gives all-ones detect
`timescale 1ns/10ps
`default_nettype none
module lsm_fabric_model
   import lsm_pkg::*;
(
   // select shared with the slice
   input wire logic [SEL_W-1:0] i_sel,
   // neighbour function outputs
   output logic o_fx_lo,
   output logic o_fx_hi
);
   assign o_fx_lo = ^i_sel;
   assign o_fx_hi = &i_sel;
endmodule : lsm_fabric_model
`default_nettype wire

// file: sim/tb.sv
// Purpose: self-checking bench of the three-slice group
// Assumes: inputs change on the falling clock edge
// Notes: every table load uses one pattern, so word n = {n[2],n[1],n[0],^n}
`timescale 1ns/10ps
`default_nettype none
module tb;
   import lsm_pkg::*;
   localparam logic [63:0] TBL = 64'hf0f0_cccc_aaaa_6996;
   logic i_mclk, i_reset, i_cfg_load, i_cfg_fast, i_lut_sel5, i_fx_lo, i_fx_hi, i_fx_sel;
   logic [1:0] i_cfg_mode, i_op_a, i_op_b, i_preload_val, o_sum, o_count;
   logic [2:0] i_cfg_op;
   logic [3:0] i_lut_in, i_ram_addr, i_ram_wdata, o_ram_rdata;
   logic i_carry_in, i_add_nsub, i_mult_bit, i_count_clr, i_count_up, i_preload, i_ram_we;
   logic o_f0, o_f1, o_f5, o_fx, o_carry_out, o_cgen, o_cprop, o_ge, o_ne, o_le;
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;

   lsm_slice u_lsm_slice (.i_mclk(i_mclk), .i_reset(i_reset), .i_cfg_load(i_cfg_load),
      .i_cfg_mode(i_cfg_mode), .i_cfg_op(i_cfg_op), .i_cfg_fast(i_cfg_fast),
      .i_cfg_tables(TBL), .i_lut_in(i_lut_in), .i_lut_sel5(i_lut_sel5), .i_fx_lo(i_fx_lo),
      .i_fx_hi(i_fx_hi), .i_fx_sel(i_fx_sel), .o_f0(o_f0), .o_f1(o_f1), .o_f5(o_f5),
      .o_fx(o_fx), .i_op_a(i_op_a), .i_op_b(i_op_b), .i_carry_in(i_carry_in),
      .i_add_nsub(i_add_nsub), .i_mult_bit(i_mult_bit), .o_sum(o_sum),
      .o_carry_out(o_carry_out), .o_cgen(o_cgen), .o_cprop(o_cprop), .o_ge(o_ge),
      .o_ne(o_ne), .o_le(o_le), .i_count_clr(i_count_clr), .i_count_up(i_count_up),
      .i_preload(i_preload), .i_preload_val(i_preload_val), .o_count(o_count),
      .i_ram_addr(i_ram_addr), .i_ram_we(i_ram_we), .i_ram_wdata(i_ram_wdata),
      .o_ram_rdata(o_ram_rdata));
   lsm_fabric_model u_lsm_fabric_model (.i_sel(i_lut_in), .o_fx_lo(i_fx_lo),
      .o_fx_hi(i_fx_hi));

   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   // hang guard
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         test_done();
      end
   end

   function automatic logic [3:0] word(input logic [3:0] n);
      return {n[2], n[1], n[0], ^n};
   endfunction : word

   task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         $display("unexpected t=%0t %s got %h exp %h", $time, what, got, exp);
         n_mismatch++;
      end
   endtask : chk

   task automatic cfg(input logic [1:0] m, input logic [2:0] op, input logic f);
      @(negedge i_mclk);
      i_cfg_mode = m;
      i_cfg_op = op;
      i_cfg_fast = f;
      i_cfg_load = 1'b1;
      @(negedge i_mclk);
      i_cfg_load = 1'b0;
   endtask : cfg

   task automatic t_logic();
      cfg(MODE_LOGIC, OP_ADD, 1'b0);
      for (int n = 0; n < 16; n++) begin
         @(negedge i_mclk);
         i_lut_in = 4'(n);
         i_lut_sel5 = n[0];
         i_fx_sel = n[1];
         #1;
         chk({3'h0, o_f0}, {3'h0, ^i_lut_in}, "table 0");
         chk({3'h0, o_f1}, {3'h0, TBL[16 + n]}, "table 1");
         chk({3'h0, o_f5}, {3'h0, TBL[16 * n[0] + n]}, "five input");
         chk({3'h0, o_fx}, {3'h0, n[1] ? &i_lut_in : ^i_lut_in}, "wide mux");
      end
      $display("test logic done");
   endtask : t_logic

   task automatic t_arith();
      logic [2:0] e;
      cfg(MODE_RIPPLE, OP_ADD, 1'b0);
      for (int k = 0; k < 16; k++) begin
         i_cfg_op = OP_ADD;
         if (k >= 4) cfg(MODE_RIPPLE, k >= 12 ? OP_MULT : 3'(k / 4), 1'b0);
         i_op_a = 2'(k);
         i_op_b = 2'(k * 3 + 1);
         i_carry_in = k[1];
         i_add_nsub = k[0];
         i_mult_bit = k[0];
         if (k >= 12) e = {1'b0, i_op_a & {2{i_mult_bit}}} + i_op_b + i_carry_in;
         else if (k < 4 || (k >= 8 && k[0])) e = i_op_a + i_op_b + i_carry_in;
         else e = i_op_a + {1'b0, ~i_op_b} + i_carry_in;
         #1;
         if (k < 12) chk({3'h0, o_carry_out}, {3'h0, e[2]}, "carry");
         @(negedge i_mclk);
         chk({2'h0, o_sum}, {2'h0, e[1:0]}, "sum");
      end
      cfg(MODE_RIPPLE, OP_ADD, 1'b1);
      i_op_a = 2'h3;
      i_op_b = 2'h1;
      #1;
      chk({2'h0, o_cgen, o_cprop}, 4'h2, "gen");
      @(negedge i_mclk);
      i_op_a = 2'h1;
      i_op_b = 2'h2;
      #1;
      chk({2'h0, o_cgen, o_cprop}, 4'h1, "prop");
      cfg(MODE_RIPPLE, OP_ADD, 1'b0);
      chk({2'h0, o_cgen, o_cprop}, 4'h0, "no fast");
      $display("test arith done");
   endtask : t_arith

   task automatic t_count();
      for (int k = 0; k < 4; k++) begin
         cfg(MODE_RIPPLE, k < 2 ? 3'(3 + k) : OP_CNT_UD, 1'b0);
         i_count_up = (k != 3);
         i_preload = 1'b1;
         i_preload_val = 2'h2;
         @(negedge i_mclk);
         i_preload = 1'b0;
         chk({2'h0, o_count}, 4'h2, "preload");
         @(negedge i_mclk);
         chk({2'h0, o_count}, (k == 0 || k == 2) ? 4'h3 : 4'h1, "count");
      end
      i_count_clr = 1'b1;
      #1 chk({2'h0, o_count}, 4'h0, "async clear");
      @(negedge i_mclk);
      chk({2'h0, o_count}, 4'h0, "clear held");
      i_count_clr = 1'b0;
      $display("test count done");
   endtask : t_count

   task automatic t_cmp();
      cfg(MODE_RIPPLE, OP_CMP, 1'b0);
      for (int k = 0; k < 3; k++) begin
         i_op_a = 2'(2 - k);
         i_op_b = k == 2 ? 2'h3 : 2'h1;
         @(negedge i_mclk);
         chk({1'b0, o_ge, o_ne, o_le}, {1'b0, i_op_a >= i_op_b, i_op_a != i_op_b,
            i_op_a <= i_op_b}, "compare");
      end
      $display("test compare done");
   endtask : t_cmp

   task automatic t_mem(input logic [1:0] m);
      cfg(m, OP_ADD, 1'b0);
      i_ram_addr = 4'h3;
      #1;
      chk(o_ram_rdata, word(4'h3), "preloaded");
      @(negedge i_mclk);
      i_ram_addr = 4'h5;
      i_ram_wdata = 4'h9;
      i_ram_we = 1'b1;
      @(negedge i_mclk);
      i_ram_we = 1'b0;
      #1;
      chk(o_ram_rdata, m == MODE_RAM ? 4'h9 : word(4'h5), "written");
      @(negedge i_mclk);
      i_ram_addr = 4'h6;
      #1;
      chk(o_ram_rdata, word(4'h6), "neighbour word");
      $display("test memory mode %0d done", m);
   endtask : t_mem

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done

   initial begin
      {i_cfg_load, i_cfg_fast, i_lut_sel5, i_fx_sel, i_carry_in, i_add_nsub} = '0;
      {i_mult_bit, i_count_clr, i_count_up, i_preload, i_ram_we} = '0;
      {i_cfg_mode, i_cfg_op, i_lut_in, i_op_a, i_op_b, i_preload_val} = '0;
      {i_ram_addr, i_ram_wdata} = '0;
      i_reset = 1'b1;
      repeat (20) @(negedge i_mclk);
      i_reset = 1'b0;
      chk({o_sum, o_count} | {1'b0, o_ge, o_ne, o_le}, 4'h0, "reset regs");
      chk(o_ram_rdata, 4'h0, "reset tables");
      t_logic();
      t_arith();
      t_count();
      t_cmp();
      t_mem(MODE_RAM);
      t_mem(MODE_ROM);
      test_done();
   end
endmodule : tb
`default_nettype wire
